// >>> strobe_port_ctrl.sv
// Two strobed 8-bit ports with input latches, end-of-write flag and interrupt request
`timescale 1ns/1ps

// Behaviour
// - Output ports never raise flags
// - Valid strobe edge latches pins, sets flag
// - Port request gated by own enable
// - Request idles once causing flags clear
// - Method 1: clear by writing zero
// - Method 0: latch read clears flag
// - Latch clock is strobe XOR polarity
// - Strobe equal polarity keeps latch transparent
// - Polarity change acts as clock edge
// - Input-port latch clock rise sets flag
// - Plane being programmed blocked, other readable
// - Bit 6 toggles per read while programming
// - Programming done sets end-of-write flag
// - Enabled end-of-write raises request
// - Writing zero clears end-of-write flag
// - Pin state read is live, unlatched
// - Request is active-low open drain
// - Output write drives pins, pulses strobe
// - Polarity one falling, zero rising
// - Late enable with set flag asserts
module strobe_port_ctrl (
  input  wire logic                          mclk,
  input  wire logic                          reset,
  input  wire logic [7:0]                    port_a_pin_in,
  input  wire logic                          port_a_strobe_in,
  input  wire logic [7:0]                    port_b_pin_in,
  input  wire logic                          port_b_strobe_in,
  input  wire strobe_port_pkg::port_cfg_s    port_a_cfg,
  input  wire strobe_port_pkg::port_cfg_s    port_b_cfg,
  input  wire logic                          flag_clear_method,
  input  wire logic                          write_done_irq_enable,
  input  wire logic                          host_wr_a,
  input  wire logic                          host_wr_b,
  input  wire logic [7:0]                    host_wr_data,
  input  wire logic                          host_rd_latch_a,
  input  wire logic                          host_rd_latch_b,
  input  wire logic                          host_isr_wr,
  input  wire logic [strobe_port_pkg::ISR_W-1:0] host_isr_wdata,
  input  wire logic                          host_rd_last_byte,
  input  wire logic                          prog_busy,
  input  wire logic                          prog_plane_hi,
  input  wire logic                          write_done,
  output logic      [7:0]                    port_a_data_latch,
  output logic      [7:0]                    port_b_data_latch,
  output logic      [7:0]                    port_a_pin_state,
  output logic      [7:0]                    port_b_pin_state,
  output logic      [7:0]                    port_a_pin_out,
  output logic      [7:0]                    port_a_pin_oe,
  output logic      [7:0]                    port_b_pin_out,
  output logic      [7:0]                    port_b_pin_oe,
  output logic                               port_a_strobe_out,
  output logic                               port_a_strobe_oe,
  output logic                               port_b_strobe_out,
  output logic                               port_b_strobe_oe,
  output logic                               port_a_flag,
  output logic                               port_b_flag,
  output logic                               write_done_flag,
  output logic                               irq_n_out,
  output logic                               irq_n_oe,
  output logic                               toggle_bit,
  output logic                               plane_lo_blocked,
  output logic                               plane_hi_blocked
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    strobe_port_pkg::port_state_s [1:0] port;
    logic                               eow_flag;
    logic                               toggle;
    logic                               lo_blocked;
    logic                               hi_blocked;
    logic [1:0]                         settle;
    logic                               irq_oe;
    logic                               irq_out;
  } ctrl_state_s;

  ctrl_state_s state_q;
  ctrl_state_s state_d;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [8:0] sync_a;
  logic [8:0] sync_b;

  pin_sync #(.W(9)) u_sync_a (
    .mclk     (mclk),
    .reset    (reset),
    .async_in ({port_a_strobe_in, port_a_pin_in}),
    .sync_out (sync_a)
  );

  pin_sync #(.W(9)) u_sync_b (
    .mclk     (mclk),
    .reset    (reset),
    .async_in ({port_b_strobe_in, port_b_pin_in}),
    .sync_out (sync_b)
  );

  // ----------------------------------------------------------------
  // Per-port views
  // ----------------------------------------------------------------
  strobe_port_pkg::port_cfg_s [1:0] cfg;
  logic [1:0][7:0] pins;
  logic [1:0]      strobe;
  logic [1:0]      host_wr;
  logic [1:0]      host_rd;
  logic [1:0]      latch_clk;
  logic [1:0]      clk_rise;
  logic [1:0]      flag_set;
  logic [1:0]      flag_clr;

  assign cfg     = {port_b_cfg, port_a_cfg};
  assign pins    = {sync_b[7:0], sync_a[7:0]};
  assign strobe  = {sync_b[8], sync_a[8]};
  assign host_wr = {host_wr_b, host_wr_a};
  assign host_rd = {host_rd_latch_b, host_rd_latch_a};

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic req;
    req       = 1'b0;
    state_d   = state_q;
    latch_clk = '0;
    clk_rise  = '0;
    flag_set  = '0;
    flag_clr  = '0;
    if (state_q.settle != strobe_port_pkg::SYNC_SETTLE) begin
      state_d.settle = state_q.settle + 2'h1;
    end
    for (int i = 0; i < 2; i++) begin
      // A polarity flip away from a steady strobe's level also rises here
      latch_clk[i] = strobe[i] ^ cfg[i].strobe_polarity;
      // Synchronisers read zero out of reset; a false edge would set a flag
      clk_rise[i]  = latch_clk[i] & ~state_q.port[i].clk_prev
                   & (state_q.settle == strobe_port_pkg::SYNC_SETTLE);
      state_d.port[i].clk_prev = latch_clk[i];
      if (!cfg[i].dir_out) begin
        if (!latch_clk[i]) begin
          state_d.port[i].latch = pins[i];
        end
        flag_set[i] = clk_rise[i];
      end else if (host_wr[i]) begin
        state_d.port[i].latch     = host_wr_data;
        state_d.port[i].pulse_cnt = strobe_port_pkg::STROBE_PULSE_CYC;
      end else if (state_q.port[i].pulse_cnt != strobe_port_pkg::PULSE_IDLE) begin
        state_d.port[i].pulse_cnt = state_q.port[i].pulse_cnt - 5'h01;
      end
      if (!cfg[i].dir_out) begin
        state_d.port[i].pulse_cnt = strobe_port_pkg::PULSE_IDLE;
      end
      // Idle level is the inverse of the valid level
      state_d.port[i].strobe_out = cfg[i].strobe_polarity
        ^ (state_d.port[i].pulse_cnt == strobe_port_pkg::PULSE_IDLE);
      state_d.port[i].strobe_oe  = cfg[i].dir_out;
      // Open drain only ever pulls low; lines written one float as inputs
      state_d.port[i].pin_out = cfg[i].wire_or ? 8'h00 : state_d.port[i].latch;
      state_d.port[i].pin_oe  = !cfg[i].dir_out ? 8'h00
                              : (cfg[i].wire_or ? ~state_d.port[i].latch : 8'hff);
      if (flag_clear_method) begin
        flag_clr[i] = host_isr_wr & ~host_isr_wdata[i];
      end else begin
        flag_clr[i] = host_rd[i];
      end
      // Set wins over a clear in the same cycle
      state_d.port[i].flag = flag_set[i] | (state_q.port[i].flag & ~flag_clr[i]);
      req = req | (state_d.port[i].flag & cfg[i].irq_enable);
    end
    state_d.eow_flag = write_done
      | (state_q.eow_flag
         & ~(host_isr_wr & ~host_isr_wdata[strobe_port_pkg::ISR_BIT_EOW]));
    req = req | (state_d.eow_flag & write_done_irq_enable);
    state_d.irq_oe  = req;
    state_d.irq_out = 1'b0;
    if (prog_busy && host_rd_last_byte) begin
      state_d.toggle = ~state_q.toggle;
    end
    state_d.lo_blocked = prog_busy & ~prog_plane_hi;
    state_d.hi_blocked = prog_busy & prog_plane_hi;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign port_a_data_latch = state_q.port[0].latch;
  assign port_b_data_latch = state_q.port[1].latch;
  assign port_a_pin_state  = sync_a[7:0];
  assign port_b_pin_state  = sync_b[7:0];
  assign port_a_pin_out    = state_q.port[0].pin_out;
  assign port_a_pin_oe     = state_q.port[0].pin_oe;
  assign port_b_pin_out    = state_q.port[1].pin_out;
  assign port_b_pin_oe     = state_q.port[1].pin_oe;
  assign port_a_strobe_out = state_q.port[0].strobe_out;
  assign port_a_strobe_oe  = state_q.port[0].strobe_oe;
  assign port_b_strobe_out = state_q.port[1].strobe_out;
  assign port_b_strobe_oe  = state_q.port[1].strobe_oe;
  assign port_a_flag       = state_q.port[0].flag;
  assign port_b_flag       = state_q.port[1].flag;
  assign write_done_flag   = state_q.eow_flag;
  assign irq_n_out         = state_q.irq_out;
  assign irq_n_oe          = state_q.irq_oe;
  assign toggle_bit        = state_q.toggle;
  assign plane_lo_blocked  = state_q.lo_blocked;
  assign plane_hi_blocked  = state_q.hi_blocked;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (reset);

  AST_OUT_NO_FLAG: assert property (
    $rose(port_a_flag) |-> !$past(port_a_cfg.dir_out))
    else $error("output port A raised its flag");

  AST_EDGE_SETS_FLAG: assert property (
    (clk_rise[1] && !port_b_cfg.dir_out) |=> port_b_flag)
    else $error("port B edge did not set flag");

  AST_IRQ_NEEDS_FLAG: assert property (
    irq_n_oe |-> ((port_a_flag && $past(port_a_cfg.irq_enable))
                  || (port_b_flag && $past(port_b_cfg.irq_enable))
                  || (write_done_flag && $past(write_done_irq_enable))))
    else $error("request without any flag");

  AST_IRQ_RELEASE: assert property (
    (!port_a_flag && !port_b_flag && !write_done_flag) |-> !irq_n_oe)
    else $error("request held with flags clear");

  AST_CLR_BY_WRITE: assert property (
    (flag_clear_method && host_isr_wr && !host_isr_wdata[0] && !flag_set[0])
      |=> !port_a_flag)
    else $error("port A flag not cleared by write");

  AST_CLR_BY_READ: assert property (
    (!flag_clear_method && host_rd_latch_a && !flag_set[0]) |=> !port_a_flag)
    else $error("port A flag not cleared by read");

  AST_TRANSPARENT: assert property (
    (!port_a_cfg.dir_out && !latch_clk[0]) |=> port_a_data_latch == $past(sync_a[7:0]))
    else $error("port A latch not transparent");

  AST_EOW_SET: assert property (
    write_done |=> write_done_flag)
    else $error("end-of-write flag not set");

  AST_EOW_IRQ: assert property (
    (write_done && write_done_irq_enable) |=> irq_n_oe ##0 !irq_n_out)
    else $error("end-of-write request missing");

  AST_TOGGLE: assert property (
    (prog_busy && host_rd_last_byte) |=> toggle_bit != $past(toggle_bit))
    else $error("bit 6 did not toggle");

  AST_STROBE_PULSE: assert property (
    (port_a_cfg.dir_out && host_wr_a && $stable(port_a_cfg))
      |=> (port_a_strobe_out == port_a_cfg.strobe_polarity)[*8])
    else $error("port A strobe pulse too short");

  COV_INPUT_CAPTURE: cover property (
    !port_a_cfg.dir_out && port_a_cfg.irq_enable && clk_rise[0] ##1 irq_n_oe);
  COV_OUTPUT_WRITE: cover property (port_b_cfg.dir_out && host_wr_b);
  COV_EOW_IRQ: cover property (write_done && write_done_irq_enable ##1 irq_n_oe);

endmodule

// >>> strobe_port_pkg.sv
// Shared types and constants for the strobed port pair and its interrupt logic
package strobe_port_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 8;
  localparam int STROBE_PULSE_NS = 100;
  // Least time, so round up
  localparam int STROBE_PULSE_CYC_I = (STROBE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] STROBE_PULSE_CYC = 5'(STROBE_PULSE_CYC_I);
  // Edges after reset before synced pins and the edge history are both real
  localparam logic [1:0] SYNC_SETTLE = 2'h3;

  // ----------------------------------------------------------------
  // Field positions of the interrupt status write data
  // ----------------------------------------------------------------
  localparam int ISR_BIT_PORT_A = 0;
  localparam int ISR_BIT_PORT_B = 1;
  localparam int ISR_BIT_EOW    = 2;
  localparam int ISR_W          = 3;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] LATCH_RST  = 8'h00;
  localparam logic [4:0] PULSE_IDLE = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic dir_out;          // 1: port drives its pins
    logic wire_or;          // 1: open-drain drivers
    logic strobe_polarity;  // 1: falling strobe is the valid edge
    logic irq_enable;
  } port_cfg_s;

  typedef struct packed {
    logic [7:0] latch;
    logic       clk_prev;
    logic       flag;
    logic [4:0] pulse_cnt;
    logic       strobe_out;
    logic       strobe_oe;
    logic [7:0] pin_out;
    logic [7:0] pin_oe;
  } port_state_s;

endpackage

// >>> pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pin levels
`timescale 1ns/1ps

module pin_sync #(
  parameter int W = 9
) (
  input  wire logic         mclk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
  } sync_state_s;

  sync_state_s state_q;
  sync_state_s state_d;

  // First stage feeds only the second
  always_comb begin
    state_d        = state_q;
    state_d.stage1 = async_in;
    state_d.stage2 = state_q.stage1;
  end

  always_ff @(posedge mclk or posedge reset) begin
    if (reset) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign sync_out = state_q.stage2;

endmodule

// >>> strobe_port_peer.sv
// Far-side peripheral model that drives a port's data pins and strobe pin
`timescale 1ns/1ps

module strobe_port_peer #(
  parameter logic IDLE_STROBE = 1'b0
) (
  input  wire logic [7:0] dut_out,
  input  wire logic [7:0] dut_oe,
  output logic      [7:0] pin_level,
  output logic            strobe_level
);
  logic       drive;
  logic [7:0] data;

  initial begin
    drive        = 1'b0;
    data         = 8'h00;
    strobe_level = IDLE_STROBE;
  end

  // Released lines float up through the pull-ups, never hold the last value
  assign pin_level = (dut_oe & dut_out) | (~dut_oe & (drive ? data : 8'hff));

  // ----------------------------------------------------------------
  // Calls are made just after a falling edge
  // ----------------------------------------------------------------
  // Data stays put while the strobe is active and until the next call
  task automatic begin_pulse(input logic [7:0] d, input logic act);
    drive        = 1'b1;
    data         = d;
    strobe_level = act;
  endtask

  task automatic end_pulse();
    strobe_level = ~strobe_level;
  endtask

  // Lines read live must stay stable across the whole read
  task automatic set_pins(input logic [7:0] d);
    drive = 1'b1;
    data  = d;
  endtask

  task automatic release_pins();
    drive = 1'b0;
  endtask
endmodule

// >>> strobe_port_ctrl_tb.sv
// Self-checking bench for the strobed port pair and its interrupt logic
`timescale 1ns/1ps

module strobe_port_ctrl_tb;
  localparam logic [6:0] WR_A = 7'h40, WR_B = 7'h20, RD_A = 7'h10, RD_B = 7'h08;
  localparam logic [6:0] INTERRUPT_STATUS_REGISTER = 7'h04, RD_LAST = 7'h02, DONE = 7'h01;

  logic                      mclk, reset, method, wd_en, busy, plane_hi;
  logic                      wr_a, wr_b, rd_a, rd_b, isr_wr, rd_last, done;
  strobe_port_pkg::port_cfg_s cfg_a, cfg_b;
  logic [7:0]                wdata, latch_a, latch_b, state_a, state_b, cnt;
  logic [7:0]                out_a, oe_a, out_b, oe_b, pin_a, pin_b;
  logic [2:0]                isr_data;
  logic                      str_a, str_b, sout_a, soe_a, sout_b, soe_b, t0;
  logic                      flag_a, flag_b, wd_flag, irq_out, irq_oe, tog, lo_blk, hi_blk;
  int                        mismatches, samples_checked;

  strobe_port_peer #(.IDLE_STROBE(1'b0)) peer_a (.dut_out(out_a), .dut_oe(oe_a),
    .pin_level(pin_a), .strobe_level(str_a));
  strobe_port_peer #(.IDLE_STROBE(1'b1)) peer_b (.dut_out(out_b), .dut_oe(oe_b),
    .pin_level(pin_b), .strobe_level(str_b));

  strobe_port_ctrl dut (.mclk(mclk), .reset(reset), .port_a_pin_in(pin_a),
    .port_a_strobe_in(str_a), .port_b_pin_in(pin_b), .port_b_strobe_in(str_b),
    .port_a_cfg(cfg_a), .port_b_cfg(cfg_b), .flag_clear_method(method),
    .write_done_irq_enable(wd_en), .host_wr_a(wr_a), .host_wr_b(wr_b),
    .host_wr_data(wdata), .host_rd_latch_a(rd_a), .host_rd_latch_b(rd_b),
    .host_isr_wr(isr_wr), .host_isr_wdata(isr_data), .host_rd_last_byte(rd_last),
    .prog_busy(busy), .prog_plane_hi(plane_hi), .write_done(done),
    .port_a_data_latch(latch_a), .port_b_data_latch(latch_b), .port_a_pin_state(state_a),
    .port_b_pin_state(state_b), .port_a_pin_out(out_a), .port_a_pin_oe(oe_a),
    .port_b_pin_out(out_b), .port_b_pin_oe(oe_b), .port_a_strobe_out(sout_a),
    .port_a_strobe_oe(soe_a), .port_b_strobe_out(sout_b), .port_b_strobe_oe(soe_b),
    .port_a_flag(flag_a), .port_b_flag(flag_b), .write_done_flag(wd_flag),
    .irq_n_out(irq_out), .irq_n_oe(irq_oe), .toggle_bit(tog),
    .plane_lo_blocked(lo_blk), .plane_hi_blocked(hi_blk));

  always #4 mclk = ~mclk;

  // ----------------------------------------------------------------
  // Host access tasks
  // ----------------------------------------------------------------
  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  // Each host strobe follows its own bit of the mask
  task automatic drive(input logic [6:0] m);
    wr_a    = m[6];
    wr_b    = m[5];
    rd_a    = m[4];
    rd_b    = m[3];
    isr_wr  = m[2];
    rd_last = m[1];
    done    = m[0];
  endtask

  // One-cycle host pulse; returns after the taking edge has landed
  task automatic hit(input logic [6:0] m);
    drive(m);
    step(1);
    drive(7'h00);
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    mclk = 0; reset = 1; method = 0; wd_en = 0; busy = 0; plane_hi = 0;
    drive(7'h00);
    wdata = 8'h00; isr_data = 3'h0; mismatches = 0; samples_checked = 0;
    cfg_a = '{dir_out: 1'b0, wire_or: 1'b0, strobe_polarity: 1'b1, irq_enable: 1'b0};
    cfg_b = '{dir_out: 1'b0, wire_or: 1'b0, strobe_polarity: 1'b0, irq_enable: 1'b1};
    step(10); reset = 0; step(3);
    check(irq_oe, 8'h00);
    // Strobed capture on A, request masked until enabled late
    peer_a.begin_pulse(8'h5a, 1'b1); step(5);
    check(latch_a, 8'h5a);
    peer_a.end_pulse(); step(5);
    check(flag_a, 8'h01);
    check(irq_oe, 8'h00);
    peer_a.set_pins(8'h11); step(5);
    check(latch_a, 8'h5a);
    cfg_a.irq_enable = 1; step(2);
    check(irq_oe, 8'h01);
    hit(RD_A); check(flag_a, 8'h00);
    step(1); check(irq_oe, 8'h00);
    // Port B, inverted polarity, clear by writing zero
    method = 1; peer_b.begin_pulse(8'hc3, 1'b0); step(5); peer_b.end_pulse(); step(5);
    check(latch_b, 8'hc3);
    check(irq_oe, 8'h01);
    hit(RD_B); check(flag_b, 8'h01);
    step(1); isr_data = 3'b101; hit(INTERRUPT_STATUS_REGISTER); check(flag_b, 8'h00);
    step(1); check(irq_oe, 8'h00);
    // Software edge through the polarity bit, strobe held low
    method = 0; peer_a.set_pins(8'h33); step(4);
    cfg_a.strobe_polarity = 0; step(5);
    check(latch_a, 8'h33);
    check(flag_a, 8'h00);
    cfg_a.strobe_polarity = 1; step(4);
    check(flag_a, 8'h01);
    check(irq_oe, 8'h01);
    peer_a.set_pins(8'h44); step(5);
    check(latch_a, 8'h33);
    check(state_a, 8'h44);
    hit(RD_A);
    // Output port A: pins, strobe pulse width, no flags
    cfg_a.dir_out = 1; peer_a.release_pins(); step(2);
    wdata = 8'h96; hit(WR_A); cnt = {7'h00, sout_a};
    for (int i = 0; i < 19; i++) begin
      step(1); cnt = cnt + {7'h00, sout_a};
    end
    check(cnt, {3'h0, strobe_port_pkg::STROBE_PULSE_CYC});
    check(out_a, 8'h96);
    check(oe_a, 8'hff);
    check(soe_a, 8'h01);
    peer_a.begin_pulse(8'h00, 1'b1); step(4); peer_a.end_pulse(); step(5);
    check(flag_a, 8'h00);
    check(irq_oe, 8'h00);
    peer_a.release_pins();
    // Port B bidirectional through open-drain outputs
    cfg_b = '{dir_out: 1'b1, wire_or: 1'b1, strobe_polarity: 1'b0, irq_enable: 1'b1};
    step(2); wdata = 8'hf0; hit(WR_B);
    check(oe_b, 8'h0f);
    check(out_b, 8'h00);
    check(sout_b, 8'h00);
    peer_b.set_pins(8'ha5); step(4);
    check(state_b, 8'ha0);
    check(soe_b, 8'h01);
    peer_b.set_pins(8'h5f); step(4);
    check(state_b, 8'h50);
    check(flag_b, 8'h00);
    // End of write: planes, toggle bit, flag and request
    wd_en = 1; isr_data = 3'b011; hit(INTERRUPT_STATUS_REGISTER); busy = 1; plane_hi = 1; step(2);
    check({hi_blk, lo_blk}, 8'h02);
    plane_hi = 0; step(2);
    check({hi_blk, lo_blk}, 8'h01);
    for (int i = 0; i < 2; i++) begin
      t0 = tog; hit(RD_LAST); check(tog ^ t0, 8'h01);
      step(1);
    end
    hit(DONE); check(wd_flag, 8'h01);
    check(irq_oe, 8'h01);
    step(1); busy = 0; t0 = tog; hit(RD_LAST); check(tog ^ t0, 8'h00);
    step(1); hit(INTERRUPT_STATUS_REGISTER); check(wd_flag, 8'h00);
    step(1); check(irq_oe, 8'h00);
    wd_en = 0; hit(DONE); check(wd_flag, 8'h01);
    step(1); check(irq_oe, 8'h00);
    check(irq_out, 8'h00);
    check(sout_b, 8'h01);
    finish_test();
  end

  // Whole run is about 125 cycles
  initial begin
    repeat (5000) @(posedge mclk);
    mismatches++;
    finish_test();
  end
endmodule
